// [include/pwrclk_regs.svh]
// register map, field positions and timing counts for the power and clock controller
`ifndef PWRCLK_REGS_SVH
`define PWRCLK_REGS_SVH
`define PWRCLK_OFS_OSC_CONTROL   4'h0
`define PWRCLK_OFS_PLL_CONFIG    4'h4
`define PWRCLK_OFS_PERIPH_STOP_IN_IDLE   4'h8
`define PWRCLK_OFS_STATUS        4'hc
`define PWRCLK_BIT_SLEEP_SEL     4
`define PWRCLK_BIT_OSC_SWITCH    0
`define PWRCLK_DIV_HI            20
`define PWRCLK_DIV_LO            19
`define PWRCLK_NOSC_HI           10
`define PWRCLK_NOSC_LO           8
`define PWRCLK_OSC_RST           32'h0000_0000
`define PWRCLK_CFG_RST           32'hfff8_ffff
`define PWRCLK_STOP_IN_IDLE_RST          32'h0000_0000
`define PWRCLK_ODIV_HI           18
`define PWRCLK_ODIV_LO           16
`define PWRCLK_UPLL_BIT          15
`define PWRCLK_UIDIV_HI          10
`define PWRCLK_UIDIV_LO          8
`define PWRCLK_MUL_HI            6
`define PWRCLK_MUL_LO            4
`define PWRCLK_IDIV_HI           2
`define PWRCLK_IDIV_LO           0
`define PWRCLK_CFG_WR_MASK       32'h0007_8777
`define PWRCLK_OSC_START_US      10
`define PWRCLK_PLL_LOCK_US       20
`define PWRCLK_CLK_MHZ           20
`define PWRCLK_OSC_START_CYC     (`PWRCLK_OSC_START_US * `PWRCLK_CLK_MHZ)
`define PWRCLK_PLL_LOCK_CYC      (`PWRCLK_PLL_LOCK_US * `PWRCLK_CLK_MHZ)
`endif

// [include/pwrclk_pkg.sv]
// types shared by the power and clock controller
package pwrclk_pkg;
	typedef enum logic [1:0] {
		PWRCLK_RUN   = 2'b00,
		PWRCLK_IDLE  = 2'b01,
		PWRCLK_SLEEP = 2'b10
	} pwrclk_mode_e;
	typedef enum logic [1:0] {
		PWRCLK_SRC_STABLE = 2'b00,
		PWRCLK_SRC_OSC    = 2'b01,
		PWRCLK_SRC_LOCK   = 2'b10
	} pwrclk_sw_e;
endpackage

// [hdl/pwrclk_sync2.sv]
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module pwrclk_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// [hdl/pwrclk_ctrl.sv]
// sleep/idle control, peripheral clock scaling, clock switch delays, pll config decode
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`include "pwrclk_regs.svh"
// Operation
// - Sleep ends when an enabled sleep-capable interrupt has priority above the cpu's.
// - Any reset or watchdog timeout leaves both sleep and idle.
// - A sleep wake at or below cpu priority keeps the cpu halted and moves to idle.
// - Idle halts the cpu but keeps the system clock running.
// - Peripherals with their stop-in-idle bit set halt in idle, others keep running.
// - A wait with the sleep-select bit clear enters idle.
// - An idle interrupt not above cpu priority keeps the cpu halted in idle.
// - The peripheral clock divides the system clock by 1, 2, 4 or 8 from a two-bit field.
// - The system-clock domain modules are gated only by sleep, never by the divisor.
// - A peripheral read completes only at the next peripheral clock edge.
// - Switching to a stopped crystal or pll source inserts start and lock delays.
// - The pll output divisor code maps to 1, 2, 4, 8, 16, 32, 64 and 256.
// - Config bit 15 set disables and bypasses the usb pll, clear enables it.
// - The pll multiplier code maps to 15, 16, 17, 18, 19, 20, 21 and 24.
module pwrclk_ctrl
	import pwrclk_pkg::*;
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RESETN,
	// avalon-mm slave
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// cpu and interrupt controller
	input  wire logic        WAIT_EXEC,
	input  wire logic        IRQ_PENDING,
	input  wire logic        IRQ_SLEEP_CAPABLE,
	input  wire logic [2:0]  IRQ_PRIORITY,
	input  wire logic [2:0]  CPU_PRIORITY,
	// asynchronous wake sources
	input  wire logic        WATCHDOG_TIMEOUT,
	input  wire logic        DEVICE_RESET_REQ,
	// peripheral read request on the scaled bus
	input  wire logic        PB_READ_REQ,
	output logic             PB_READ_DONE,
	// clock gates and status
	output logic             CPU_CLK_EN,
	output logic             CORE_SYSTEM_CLOCK_EN,
	output logic             PERIPH_BUS_CLOCK_EN,
	output logic [31:0]      PERIPH_RUN_EN,
	output logic [1:0]       POWER_MODE,
	output logic             CLK_SWITCH_BUSY,
	// decoded pll settings
	output logic [8:0]       PLL_OUT_DIV,
	output logic [4:0]       PLL_MULT,
	output logic [2:0]       PLL_IN_DIV_CODE,
	output logic             USB_PLL_ENABLE,
	output logic [3:0]       USB_PLL_IN_DIV
);
	pwrclk_mode_e mode_q;
	pwrclk_sw_e   sw_q;
	logic [31:0] osc_control_reg_q;
	logic [31:0] pll_config_word_q;
	logic [31:0] stop_in_idle_q;
	logic [31:0] rdata_q;
	logic        ack_q;
	logic [2:0]  cur_src_q;
	logic [7:0]  src_on_q;
	logic [15:0] dly_q;
	logic [2:0]  pb_cnt_q;
	logic        pb_edge;
	logic        wdt_s;
	logic        rst_s;
	logic        wake_hi;
	logic        wake_any;
	logic        acc;
	logic [1:0]  periph_bus_divisor;
	logic [2:0]  div_mask;
	logic [2:0]  new_src;
	logic        sleep_on_wait_select;
	logic [31:0] wmask;

	pwrclk_sync2 #(.W(2)) u_sync (
		.clk    (CLK),
		.resetn (RESETN),
		.d      ({WATCHDOG_TIMEOUT, DEVICE_RESET_REQ}),
		.q      ({wdt_s, rst_s})
	);

	assign sleep_on_wait_select = osc_control_reg_q[`PWRCLK_BIT_SLEEP_SEL];
	assign periph_bus_divisor   = osc_control_reg_q[`PWRCLK_DIV_HI:`PWRCLK_DIV_LO];
	assign new_src              = osc_control_reg_q[`PWRCLK_NOSC_HI:`PWRCLK_NOSC_LO];
	assign wake_any = IRQ_PENDING && (mode_q == PWRCLK_IDLE || IRQ_SLEEP_CAPABLE);
	assign wake_hi  = wake_any && (IRQ_PRIORITY > CPU_PRIORITY);

	// power mode sequencing
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			mode_q <= PWRCLK_RUN;
		end else begin
			case (mode_q)
				PWRCLK_RUN: begin
					if (WAIT_EXEC && !wdt_s && !rst_s) begin
						mode_q <= sleep_on_wait_select ? PWRCLK_SLEEP : PWRCLK_IDLE;
					end
				end
				PWRCLK_SLEEP: begin
					if (wdt_s || rst_s || wake_hi) begin
						mode_q <= PWRCLK_RUN;
					end else if (wake_any) begin
						mode_q <= PWRCLK_IDLE;
					end
				end
				PWRCLK_IDLE: begin
					if (wdt_s || rst_s || wake_hi) begin
						mode_q <= PWRCLK_RUN;
					end // low priority leaves idle in place
				end
				default: mode_q <= PWRCLK_RUN;
			endcase
		end
	end

	// no start delay on idle exit: the source never stopped
	assign CPU_CLK_EN           = (mode_q == PWRCLK_RUN) && (sw_q == PWRCLK_SRC_STABLE);
	assign CORE_SYSTEM_CLOCK_EN = (mode_q != PWRCLK_SLEEP);
	assign PERIPH_BUS_CLOCK_EN  = (mode_q != PWRCLK_SLEEP) && pb_edge;
	assign PERIPH_RUN_EN = (mode_q == PWRCLK_SLEEP) ? 32'h0000_0000 :
		(mode_q == PWRCLK_IDLE) ? ~stop_in_idle_q : 32'hffff_ffff;
	assign POWER_MODE      = mode_q;
	assign CLK_SWITCH_BUSY = (sw_q != PWRCLK_SRC_STABLE);

	// peripheral clock divider: enable pulse once per divided period
	always_comb begin
		case (periph_bus_divisor)
			2'h0:    div_mask = 3'h0;
			2'h1:    div_mask = 3'h1;
			2'h2:    div_mask = 3'h3;
			default: div_mask = 3'h7;
		endcase
	end
	assign pb_edge = ((pb_cnt_q & div_mask) == 3'h0);

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			pb_cnt_q <= 3'h0;
		end else if (mode_q != PWRCLK_SLEEP) begin
			pb_cnt_q <= pb_cnt_q + 3'h1;
		end
	end

	assign PB_READ_DONE = PB_READ_REQ && PERIPH_BUS_CLOCK_EN;

	// clock source switch with start-up and lock delays
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			sw_q      <= PWRCLK_SRC_STABLE;
			dly_q     <= 16'h0000;
			cur_src_q <= 3'h0;
			src_on_q  <= 8'h01;
		end else begin
			case (sw_q)
				PWRCLK_SRC_STABLE: begin
					if (osc_control_reg_q[`PWRCLK_BIT_OSC_SWITCH] && new_src != cur_src_q) begin
						// codes 1..3 run on a crystal and/or the pll
						if (!src_on_q[new_src] && new_src != 3'h0 && new_src < 3'h4) begin
							sw_q  <= PWRCLK_SRC_OSC;
							dly_q <= 16'(`PWRCLK_OSC_START_CYC - 1);
						end else begin
							cur_src_q <= new_src;
						end
						src_on_q <= 8'h01 | (8'h01 << new_src) | (8'h01 << cur_src_q);
					end
				end
				PWRCLK_SRC_OSC: begin
					if (dly_q == 16'h0000) begin
						sw_q  <= PWRCLK_SRC_LOCK;
						dly_q <= 16'(`PWRCLK_PLL_LOCK_CYC - 1);
					end else begin
						dly_q <= dly_q - 16'h0001;
					end
				end
				PWRCLK_SRC_LOCK: begin
					if (dly_q == 16'h0000) begin
						sw_q      <= PWRCLK_SRC_STABLE;
						cur_src_q <= new_src;
					end else begin
						dly_q <= dly_q - 16'h0001;
					end
				end
				default: sw_q <= PWRCLK_SRC_STABLE;
			endcase
		end
	end

	// avalon slave: one wait state, then ack
	assign acc             = (AVS_READ || AVS_WRITE) && !ack_q;
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;
	assign AVS_READDATA    = rdata_q;
	assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
		{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= acc;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			osc_control_reg_q <= `PWRCLK_OSC_RST;
			pll_config_word_q <= `PWRCLK_CFG_RST;
			stop_in_idle_q    <= `PWRCLK_STOP_IN_IDLE_RST;
		end else begin
			if (sw_q == PWRCLK_SRC_LOCK && dly_q == 16'h0000) begin
				osc_control_reg_q[`PWRCLK_BIT_OSC_SWITCH] <= 1'b0;
			end else if (sw_q == PWRCLK_SRC_STABLE && new_src == cur_src_q) begin
				osc_control_reg_q[`PWRCLK_BIT_OSC_SWITCH] <= 1'b0;
			end
			// the write lands on the edge that sees waitrequest low
			if (AVS_WRITE && ack_q) begin
				if (AVS_ADDRESS == `PWRCLK_OFS_OSC_CONTROL) begin
					osc_control_reg_q <= (osc_control_reg_q & ~wmask) | (AVS_WRITEDATA & wmask);
				end else if (AVS_ADDRESS == `PWRCLK_OFS_PLL_CONFIG) begin
					// reserved bits stay one
					pll_config_word_q <= (pll_config_word_q & ~(wmask & `PWRCLK_CFG_WR_MASK))
						| (AVS_WRITEDATA & wmask & `PWRCLK_CFG_WR_MASK);
				end else if (AVS_ADDRESS == `PWRCLK_OFS_PERIPH_STOP_IN_IDLE) begin
					stop_in_idle_q <= (stop_in_idle_q & ~wmask) | (AVS_WRITEDATA & wmask);
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			rdata_q <= 32'h0000_0000;
		end else if (acc && AVS_READ) begin
			if (AVS_ADDRESS == `PWRCLK_OFS_OSC_CONTROL) begin
				rdata_q <= osc_control_reg_q;
			end else if (AVS_ADDRESS == `PWRCLK_OFS_PLL_CONFIG) begin
				rdata_q <= pll_config_word_q;
			end else if (AVS_ADDRESS == `PWRCLK_OFS_PERIPH_STOP_IN_IDLE) begin
				rdata_q <= stop_in_idle_q;
			end else if (AVS_ADDRESS == `PWRCLK_OFS_STATUS) begin
				rdata_q <= {24'h00_0000, 1'b0, cur_src_q, CLK_SWITCH_BUSY, 1'b0, mode_q};
			end else begin
				rdata_q <= 32'h0000_0000;
			end
		end
	end

	// pll configuration decode, registered
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			PLL_OUT_DIV     <= 9'h001;
			PLL_MULT        <= 5'h0f;
			PLL_IN_DIV_CODE <= 3'h0;
			USB_PLL_ENABLE  <= 1'b0;
			USB_PLL_IN_DIV  <= 4'h1;
		end else begin
			case (pll_config_word_q[`PWRCLK_ODIV_HI:`PWRCLK_ODIV_LO])
				3'h0:    PLL_OUT_DIV <= 9'h001;
				3'h1:    PLL_OUT_DIV <= 9'h002;
				3'h2:    PLL_OUT_DIV <= 9'h004;
				3'h3:    PLL_OUT_DIV <= 9'h008;
				3'h4:    PLL_OUT_DIV <= 9'h010;
				3'h5:    PLL_OUT_DIV <= 9'h020;
				3'h6:    PLL_OUT_DIV <= 9'h040;
				default: PLL_OUT_DIV <= 9'h100;
			endcase
			case (pll_config_word_q[`PWRCLK_MUL_HI:`PWRCLK_MUL_LO])
				3'h7:    PLL_MULT <= 5'h18;
				default: PLL_MULT <= 5'h0f + {2'h0, pll_config_word_q[`PWRCLK_MUL_HI:`PWRCLK_MUL_LO]};
			endcase
			case (pll_config_word_q[`PWRCLK_UIDIV_HI:`PWRCLK_UIDIV_LO])
				3'h6:    USB_PLL_IN_DIV <= 4'ha;
				3'h7:    USB_PLL_IN_DIV <= 4'hc;
				default: USB_PLL_IN_DIV <= 4'h1 + {1'b0, pll_config_word_q[`PWRCLK_UIDIV_HI:`PWRCLK_UIDIV_LO]};
			endcase
			USB_PLL_ENABLE  <= !pll_config_word_q[`PWRCLK_UPLL_BIT];
			PLL_IN_DIV_CODE <= pll_config_word_q[`PWRCLK_IDIV_HI:`PWRCLK_IDIV_LO];
		end
	end

	a_sleep_hi_wake: assert property (@(posedge CLK) disable iff (!RESETN)
		(mode_q == PWRCLK_SLEEP && wake_hi) |=> mode_q == PWRCLK_RUN) else $error("sleep did not wake");
	a_wdt_exits: assert property (@(posedge CLK) disable iff (!RESETN)
		(mode_q != PWRCLK_RUN && wdt_s) |=> mode_q == PWRCLK_RUN) else $error("watchdog exit missed");
	a_sleep_to_idle: assert property (@(posedge CLK) disable iff (!RESETN)
		(mode_q == PWRCLK_SLEEP && wake_any && !wake_hi && !wdt_s && !rst_s)
		|=> mode_q == PWRCLK_IDLE && !CPU_CLK_EN) else $error("low wake not idle");
	a_idle_core_system_clock: assert property (@(posedge CLK) disable iff (!RESETN)
		mode_q == PWRCLK_IDLE |-> CORE_SYSTEM_CLOCK_EN && !CPU_CLK_EN) else $error("idle gating");
	a_stop_in_idle_gate: assert property (@(posedge CLK) disable iff (!RESETN)
		mode_q == PWRCLK_IDLE |-> PERIPH_RUN_EN == ~stop_in_idle_q) else $error("stop_in_idle gate");
	a_wait_idle: assert property (@(posedge CLK) disable iff (!RESETN)
		(mode_q == PWRCLK_RUN && WAIT_EXEC && !wdt_s && !rst_s && !sleep_on_wait_select)
		|=> mode_q == PWRCLK_IDLE) else $error("wait not idle");
	a_sleep_clk_off: assert property (@(posedge CLK) disable iff (!RESETN)
		mode_q == PWRCLK_SLEEP |-> !CORE_SYSTEM_CLOCK_EN && !PERIPH_BUS_CLOCK_EN) else $error("sleep clk");
	a_idle_low_stay: assert property (@(posedge CLK) disable iff (!RESETN)
		(mode_q == PWRCLK_IDLE && !wake_hi && !wdt_s && !rst_s) |=> mode_q == PWRCLK_IDLE) else $error("idle left");
	a_pb_div8: assert property (@(posedge CLK) disable iff (!RESETN)
		(PERIPH_BUS_CLOCK_EN && periph_bus_divisor == 2'h3 && $stable(periph_bus_divisor))
		|=> (!pb_edge || periph_bus_divisor != 2'h3) [*7]) else $error("div8 period");
	a_read_wait: assert property (@(posedge CLK) disable iff (!RESETN)
		PB_READ_DONE |-> PERIPH_BUS_CLOCK_EN) else $error("read early");
	a_usb_pll_en: assert property (@(posedge CLK) disable iff (!RESETN)
		$past(pll_config_word_q[`PWRCLK_UPLL_BIT]) |-> !USB_PLL_ENABLE) else $error("usb pll en");
endmodule

// [test/pwrclk_cpu_model.sv]
// cpu core and interrupt controller model facing the power controller
`timescale 1ns/10ps
module pwrclk_cpu_model (
	// clock
	input  wire logic       clk,
	// from the controller
	input  wire logic       cpu_clk_en,
	input  wire logic       pb_read_done,
	// to the controller
	output logic            wait_exec,
	output logic            irq_pending,
	output logic            irq_sleep_capable,
	output logic [2:0]      irq_priority,
	output logic [2:0]      cpu_priority,
	output logic            pb_read_req
);
	initial begin
		wait_exec = 1'b0;
		irq_pending = 1'b0;
		irq_sleep_capable = 1'b0;
		irq_priority = 3'h0;
		cpu_priority = 3'h3;
		pb_read_req = 1'b0;
	end
	// a halted core cannot execute a wait
	task automatic exec_wait();
		@(posedge clk);
		if (cpu_clk_en === 1'b1)
			wait_exec <= 1'b1;
		@(posedge clk);
		wait_exec <= 1'b0;
	endtask
	// the request stays up until the bench withdraws it, as a real source would
	task automatic irq(input logic on, input logic cap, input logic [2:0] pri);
		@(posedge clk);
		irq_pending <= on;
		irq_sleep_capable <= cap;
		irq_priority <= pri;
	endtask
	// read held until done is seen at an edge
	task automatic pb_read(output int waited);
		waited = 0;
		@(posedge clk);
		pb_read_req <= 1'b1;
		do begin
			@(posedge clk);
			waited++;
		end while (pb_read_done !== 1'b1 && waited < 20);
		pb_read_req <= 1'b0;
	endtask
endmodule

// [test/pwrclk_ctrl_tb_top.sv]
// self-checking bench for the power and clock controller
`timescale 1ns/10ps
`include "pwrclk_regs.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_total++; \
	$display("BAD %s exp %0h got %0h", nm, ex, got); end end
module pwrclk_ctrl_tb_top;
	import pwrclk_pkg::*;
	logic CLK, RESETN, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, WDT, DRST;
	logic [3:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, PERIPH_RUN_EN, rd;
	logic WAIT_EXEC, IRQ_PENDING, IRQ_CAP, PB_REQ, PB_DONE, CPU_EN, SYS_EN, PB_EN, BUSY, UPLL_EN;
	logic [2:0] IRQ_PRI, CPU_PRI, IDIV;
	logic [1:0] MODE;
	logic [8:0] ODIV;
	logic [4:0] MULT;
	logic [3:0] UDIV;
	int err_total, samples_checked, cyc, n;
	int odiv_t[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
	int mult_t[8] = '{15, 16, 17, 18, 19, 20, 21, 24};
	int udiv_t[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
	pwrclk_ctrl DUT (.CLK(CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .WAIT_EXEC(WAIT_EXEC),
		.IRQ_PENDING(IRQ_PENDING), .IRQ_SLEEP_CAPABLE(IRQ_CAP), .IRQ_PRIORITY(IRQ_PRI),
		.CPU_PRIORITY(CPU_PRI), .WATCHDOG_TIMEOUT(WDT), .DEVICE_RESET_REQ(DRST),
		.PB_READ_REQ(PB_REQ), .PB_READ_DONE(PB_DONE), .CPU_CLK_EN(CPU_EN),
		.CORE_SYSTEM_CLOCK_EN(SYS_EN), .PERIPH_BUS_CLOCK_EN(PB_EN), .PERIPH_RUN_EN(PERIPH_RUN_EN),
		.POWER_MODE(MODE), .CLK_SWITCH_BUSY(BUSY), .PLL_OUT_DIV(ODIV), .PLL_MULT(MULT),
		.PLL_IN_DIV_CODE(IDIV), .USB_PLL_ENABLE(UPLL_EN), .USB_PLL_IN_DIV(UDIV));
	pwrclk_cpu_model cpu (.clk(CLK), .cpu_clk_en(CPU_EN), .pb_read_done(PB_DONE),
		.wait_exec(WAIT_EXEC), .irq_pending(IRQ_PENDING), .irq_sleep_capable(IRQ_CAP),
		.irq_priority(IRQ_PRI), .cpu_priority(CPU_PRI), .pb_read_req(PB_REQ));
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	task automatic finish_test();
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// one edge first so a new request never lands in the step of the last release
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge CLK);
		AVS_ADDRESS <= a;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		AVS_WRITEDATA <= wd;
		do begin
			@(posedge CLK);
			k++;
		end while (AVS_WAITREQUEST !== 1'b0 && k < 50);
		rd = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask
	task automatic wait_mode(input logic [1:0] m, input int lim);
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (MODE !== m && n < lim);
	endtask
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end
	initial begin
		{RESETN, AVS_READ, AVS_WRITE, WDT, DRST, AVS_ADDRESS, AVS_WRITEDATA} = '0;
		repeat (20) @(posedge CLK);
		RESETN <= 1'b1;
		bus(0, 4'h4, 0);
		`CHK("cfg_rst", `PWRCLK_CFG_RST, rd)
		bus(0, 4'h2, 0);
		`CHK("unmapped", 32'h0, rd)
		`CHK("rst_mult", 5'd24, MULT)
		`CHK("rst_upll", 1'b0, UPLL_EN)
		for (int i = 0; i < 8; i++) begin
			// reserved bits written as ones, every field left at zero before or-ing
			bus(1, 4'h4, 32'hfff8_7888 | (i << 16) | (i << 8) | (i << 4) | (i[0] << 15));
			repeat (2) @(posedge CLK);
			`CHK("odiv", 9'(odiv_t[i]), ODIV)
			`CHK("mult", 5'(mult_t[i]), MULT)
			`CHK("udiv", 4'(udiv_t[i]), UDIV)
			`CHK("upll", ~i[0], UPLL_EN)
		end
		for (int d = 0; d < 4; d++) begin
			bus(1, 4'h0, d << 19);
			n = 0;
			repeat (32) begin
				@(posedge CLK);
				n += int'(PB_EN === 1'b1);
				`CHK("sys_on", 1'b1, SYS_EN)
			end
			`CHK("pb_rate", 32 >> d, n)
		end
		repeat (3) begin
			cpu.pb_read(n);
			`CHK("pb_edge", 1'b1, PB_EN)
			`CHK("pb_wait", 1'b1, n <= 8)
		end
		bus(1, 4'h8, 32'h0000_00a5);
		bus(1, 4'h0, 32'h0);
		cpu.exec_wait();
		wait_mode(PWRCLK_IDLE, 4);
		`CHK("idle", PWRCLK_IDLE, MODE)
		`CHK("idle_cpu", 1'b0, CPU_EN)
		`CHK("idle_sys", 1'b1, SYS_EN)
		`CHK("idle_run", 32'hffff_ff5a, PERIPH_RUN_EN)
		cpu.irq(1, 0, 3'h3);
		repeat (6) @(posedge CLK);
		`CHK("idle_low", PWRCLK_IDLE, MODE)
		cpu.irq(1, 0, 3'h4);
		wait_mode(PWRCLK_RUN, 4);
		`CHK("idle_wake", 1'b1, CPU_EN & !BUSY)
		cpu.irq(0, 0, 3'h0);
		bus(1, 4'h0, 32'h10);
		cpu.exec_wait();
		wait_mode(PWRCLK_SLEEP, 4);
		`CHK("sleep_sys", 1'b0, SYS_EN | PB_EN | CPU_EN)
		`CHK("sleep_run", 32'h0, PERIPH_RUN_EN)
		cpu.irq(1, 1, 3'h2);
		wait_mode(PWRCLK_IDLE, 4);
		`CHK("slp_low", PWRCLK_IDLE, MODE)
		`CHK("slp_low_cpu", 1'b0, CPU_EN)
		cpu.irq(0, 0, 3'h0);
		WDT <= 1'b1;
		wait_mode(PWRCLK_RUN, 8);
		`CHK("wdt_idle", PWRCLK_RUN, MODE)
		WDT <= 1'b0;
		repeat (4) @(posedge CLK);
		cpu.exec_wait();
		wait_mode(PWRCLK_SLEEP, 4);
		cpu.irq(1, 1, 3'h5);
		wait_mode(PWRCLK_RUN, 4);
		`CHK("slp_wake", PWRCLK_RUN, MODE)
		cpu.irq(0, 0, 3'h0);
		cpu.exec_wait();
		wait_mode(PWRCLK_SLEEP, 4);
		DRST <= 1'b1;
		wait_mode(PWRCLK_RUN, 8);
		`CHK("rst_slp", PWRCLK_RUN, MODE)
		DRST <= 1'b0;
		repeat (4) @(posedge CLK);
		bus(1, 4'h0, 32'h0000_0101);
		bus(0, 4'hc, 0);
		`CHK("st_busy", 1'b1, rd[3])
		n = 2;
		while (BUSY === 1'b1 && n < 2000) begin
			@(posedge CLK);
			n++;
		end
		`CHK("sw_len", 1'b1, n >= `PWRCLK_OSC_START_CYC + `PWRCLK_PLL_LOCK_CYC)
		`CHK("sw_max", 1'b1, n <= `PWRCLK_OSC_START_CYC + `PWRCLK_PLL_LOCK_CYC + 6)
		bus(0, 4'h0, 0);
		`CHK("sw_done", 1'b0, rd[0])
		finish_test();
	end
endmodule
